// file: srpsc_beat_timer.v
/*
 Beat timer: divides the core clock by the programmed setpoint and emits one-cycle beat pulses.
 Assumes a setpoint of zero means the timer is halted.
*/
`timescale 1ns/100ps
`include "srpsc_defines.vh"
module srpsc_beat_timer #(
    parameter WIDTH = 12
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire [WIDTH-1:0] setpoint_i,
    output reg beat_o
);
    reg [WIDTH-1:0] count;

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            count <= {WIDTH{1'b0}};
            beat_o <= 1'b0;
        end else if (setpoint_i == {WIDTH{1'b0}}) begin
            count <= {WIDTH{1'b0}};
            beat_o <= 1'b0;
        end else if (count >= setpoint_i - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            count <= {WIDTH{1'b0}};
            beat_o <= 1'b1; // R8
        end else begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            beat_o <= 1'b0;
        end
    end
endmodule // srpsc_beat_timer

// file: srpsc_checker.sv
/* Port checker of the SYSREF pulse and sync control block.
   Assumes binding to srpsc_control, one core clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module srpsc_checker (
    input wire clock_i,
    input wire rst_n_i,
    input wire reg_write_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire serial_request_i,
    input wire [5:0] general_output_function_i,
    input wire general_output_pin_o,
    input wire reseed_pll2_o,
    input wire reseed_direct_o,
    input wire request_status_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr_low;
        reg_write_i && reg_addr_i == 8'h5c ##1 !reg_write_i && reg_addr_i == 8'h5c;
    endsequence
    sequence s_wr_high;
        reg_write_i && reg_addr_i == 8'h5d ##1 !reg_write_i && reg_addr_i == 8'h5d;
    endsequence
    a_timer_low_back: assert property (s_wr_low |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("timer low readback wrong");
    a_timer_high_back: assert property (s_wr_high |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h0f))
        else $error("timer high readback wrong");
    a_unmapped_zero: assert property (reg_addr_i < 8'h5a || reg_addr_i > 8'h5d |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_gpo_quiet: assert property (general_output_function_i != 6'h3e |=> !general_output_pin_o)
        else $error("output pin driven without status function");
    a_serial_request: assert property (serial_request_i |=> request_status_o)
        else $error("serial request not seen in status");
    a_reseed_one_way: assert property (!(reseed_pll2_o && reseed_direct_o))
        else $error("reseed on both paths");
    a_pll2_single: assert property (reseed_pll2_o |=> !reseed_pll2_o)
        else $error("second PLL reseed longer than one cycle");
    a_direct_single: assert property ($rose(reseed_direct_o) |=> $fell(reseed_direct_o))
        else $error("direct reseed longer than one cycle");
endmodule // srpsc_checker
bind srpsc_control srpsc_checker checker_i (.*);

// file: srpsc_control.v
/*
 SYSREF pulse generator and sync input control with its byte register port.
 Assumes a synchronous byte write/read port from the serial control logic and synchronous pins.
 Registers wake at zero, so the generator starts in level mode with the beat timer halted.
 The reference input is sampled as a core-clock pin, so retiming resolves to one core cycle.
*/
// Summary of operation
// R1 - Mode 000 runs pulses while any pin, serial or sync request is present.
// R2 - Modes 001..110 give bursts of 1, 2, 4, 8, 16, 16 pulses.
// R3 - Mode 111 runs SYSREF continuously at 50 percent duty.
// R4 - Software uses bursts only on LVPECL or CML outputs.
// R5 - Sync register bit 2 retimes sync to reference input zero, else bypass.
// R6 - Sync register bit 1 passes reseed events through the second PLL.
// R7 - Sync register bit 0 inverts sync input; software keeps it 0 otherwise.
// R8 - A 12-bit timer setpoint at 0x5c/0x5d sets the beat rate.
// R9 - Software keeps the beat a submultiple of SYSREF and at most 4 MHz.
// R10 - Software prefers asynchronous start-up for continuous SYSREF.
// R11 - General output function 111110 shows the pulse request status.
// R12 - Bursts emit exactly N beat-aligned pulses then wait for a new request.
`timescale 1ns/100ps
`include "srpsc_defines.vh"
module srpsc_control #(
    parameter TIMER_WIDTH = 12
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire reg_write_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire serial_request_i,
    input wire general_input_pin_i,
    input wire [3:0] input_pin_function_select_i,
    input wire sync_pin_i,
    input wire reference_input_zero_i,
    input wire [5:0] general_output_function_i,
    output reg general_output_pin_o,
    output reg sysref_o,
    output reg reseed_pll2_o,
    output reg reseed_direct_o,
    output reg request_status_o
);
    // DONE holds off a new burst until the request that started it has dropped.
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [7:0] pulse_generator_mode;
    reg [7:0] sync_input_control;
    reg [7:0] beat_timer_low;
    reg [7:0] beat_timer_high;
    reg [1:0] state;
    reg [5:0] edges_left;
    reg ref_q;
    reg sync_retimed;
    reg sync_prev;
    reg [5:0] next_edges;
    reg [7:0] next_rdata;
    wire beat;
    wire [2:0] mode;
    wire sync_raw;
    wire sync_level;
    wire sync_event;
    wire request;
    wire request_rise;
    wire pin_request;
    wire burst_mode;
    reg request_prev;

    assign mode = pulse_generator_mode[2:0];
    assign sync_raw = sync_pin_i ^ sync_input_control[`SRPSC_SYNC_POL_BIT]; // R7
    // Retimed sync is sampled on a reference rising edge; bypass feeds the raw pin straight on.
    assign sync_level = sync_input_control[`SRPSC_SYNC_RETIME_BIT] ? sync_retimed : sync_raw; // R5
    assign sync_event = sync_level & ~sync_prev;
    assign pin_request = general_input_pin_i & (input_pin_function_select_i == `SRPSC_GPI_FUNC_PULSE_REQ); // R1
    assign request = serial_request_i | sync_level | pin_request; // R1
    assign burst_mode = (mode != `SRPSC_MODE_LEVEL) && (mode != `SRPSC_MODE_CONT); // R2
    assign request_rise = request & ~request_prev;

    // The setpoint is read live: lowering it wraps the count at once rather than waiting out the old period.
    srpsc_beat_timer #(
        .WIDTH(TIMER_WIDTH)
    ) u_beat_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .setpoint_i({beat_timer_high[3:0], beat_timer_low}),
        .beat_o(beat)
    ); // R8

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            pulse_generator_mode <= `SRPSC_RESET_BYTE;
            sync_input_control <= `SRPSC_RESET_BYTE;
            beat_timer_low <= `SRPSC_RESET_BYTE;
            beat_timer_high <= `SRPSC_RESET_BYTE;
        end else if (reg_write_i) begin
            // Reserved bits are stored as zero, so a read-back shows only what the logic uses.
            case (reg_addr_i)
                `SRPSC_ADDR_PULSE_MODE: pulse_generator_mode <= {5'h00, reg_wdata_i[2:0]};
                `SRPSC_ADDR_SYNC_CTRL: sync_input_control <= {5'h00, reg_wdata_i[2:0]};
                `SRPSC_ADDR_TIMER_LOW: beat_timer_low <= reg_wdata_i; // R8
                `SRPSC_ADDR_TIMER_HIGH: beat_timer_high <= {4'h0, reg_wdata_i[3:0]}; // R8
                default: ;
            endcase
        end
    end

    always @* begin
        case (reg_addr_i)
            `SRPSC_ADDR_PULSE_MODE: next_rdata = pulse_generator_mode;
            `SRPSC_ADDR_SYNC_CTRL: next_rdata = sync_input_control;
            `SRPSC_ADDR_TIMER_LOW: next_rdata = beat_timer_low;
            `SRPSC_ADDR_TIMER_HIGH: next_rdata = beat_timer_high;
            default: next_rdata = 8'h00;
        endcase
    end

    // Burst length counted in sysref edges: two per pulse, so 2N toggles on the beat.
    always @* begin
        case (mode)
            `SRPSC_MODE_ONE: next_edges = 6'h02; // R2
            `SRPSC_MODE_TWO: next_edges = 6'h04; // R2
            `SRPSC_MODE_FOUR: next_edges = 6'h08; // R2
            `SRPSC_MODE_EIGHT: next_edges = 6'h10; // R2
            `SRPSC_MODE_SIXTEEN_A: next_edges = 6'h20; // R2
            `SRPSC_MODE_SIXTEEN_B: next_edges = 6'h20; // R2
            default: next_edges = 6'h00;
        endcase
    end

    // A reference edge is taken on the first core clock that samples it high; the sampled sync level is held between edges.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            ref_q <= 1'b0;
            sync_retimed <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            ref_q <= reference_input_zero_i;
            if (reference_input_zero_i && !ref_q) begin
                sync_retimed <= sync_raw; // R5
            end
            sync_prev <= sync_level;
        end
    end

    // The path bit is taken at the moment of the sync edge, so a later rewrite cannot split a pulse.
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            reseed_pll2_o <= 1'b0;
            reseed_direct_o <= 1'b0;
        end else begin
            reseed_pll2_o <= sync_event & sync_input_control[`SRPSC_SYNC_PLL2_BIT]; // R6
            reseed_direct_o <= sync_event & ~sync_input_control[`SRPSC_SYNC_PLL2_BIT]; // R6
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            request_prev <= 1'b0;
            reg_rdata_o <= 8'h00;
            request_status_o <= 1'b0;
            general_output_pin_o <= 1'b0;
        end else begin
            request_prev <= request;
            reg_rdata_o <= next_rdata;
            request_status_o <= request;
            general_output_pin_o <= (general_output_function_i == `SRPSC_GPO_FUNC_PULSE_STATUS) & request; // R11
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            edges_left <= 6'h00;
            sysref_o <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Continuous mode starts without any request, free of the sync path.
                    if (mode == `SRPSC_MODE_CONT) begin
                        state <= ST_RUN; // R3
                    end else if (mode == `SRPSC_MODE_LEVEL) begin
                        if (request) begin
                            state <= ST_RUN; // R1
                        end
                    end else if (request_rise) begin
                        edges_left <= next_edges; // R12
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (mode == `SRPSC_MODE_CONT) begin
                        if (beat) begin
                            sysref_o <= ~sysref_o; // R3
                        end
                    end else if (mode == `SRPSC_MODE_LEVEL) begin
                        // Stopping waits for the low half so no runt pulse leaves the pin.
                        if (!request && !sysref_o) begin
                            state <= ST_IDLE; // R1
                        end else if (beat) begin
                            sysref_o <= request ? ~sysref_o : 1'b0; // R1
                        end
                    end else if (edges_left == 6'h00) begin
                        sysref_o <= 1'b0;
                        state <= ST_DONE; // R12
                    end else if (beat) begin
                        sysref_o <= ~sysref_o; // R12
                        edges_left <= edges_left - 6'h01;
                    end
                end
                ST_DONE: begin
                    // A held request must drop and rise again before the next burst.
                    if (!request || !burst_mode) begin
                        state <= ST_IDLE; // R12
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sysref_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // srpsc_control

// file: srpsc_defines.vh
/*
 Register offsets, field positions and mode codes of the SYSREF pulse and sync control block.
 Assumes inclusion by bare name from the block's design files.
*/
`ifndef SRPSC_DEFINES_VH
`define SRPSC_DEFINES_VH
`define SRPSC_ADDR_PULSE_MODE 8'h5a
`define SRPSC_ADDR_SYNC_CTRL 8'h5b
`define SRPSC_ADDR_TIMER_LOW 8'h5c
`define SRPSC_ADDR_TIMER_HIGH 8'h5d
`define SRPSC_ADDR_MISC 8'h5e
`define SRPSC_MODE_LEVEL 3'h0
`define SRPSC_MODE_ONE 3'h1
`define SRPSC_MODE_TWO 3'h2
`define SRPSC_MODE_FOUR 3'h3
`define SRPSC_MODE_EIGHT 3'h4
`define SRPSC_MODE_SIXTEEN_A 3'h5
`define SRPSC_MODE_SIXTEEN_B 3'h6
`define SRPSC_MODE_CONT 3'h7
`define SRPSC_SYNC_POL_BIT 0
`define SRPSC_SYNC_PLL2_BIT 1
`define SRPSC_SYNC_RETIME_BIT 2
`define SRPSC_GPI_FUNC_PULSE_REQ 4'h8
`define SRPSC_GPO_FUNC_PULSE_STATUS 6'h3e
`define SRPSC_RESET_BYTE 8'h00
`endif

// file: srpsc_sysref_receiver.sv
/* Receiver model standing for a converter fed by one SYSREF output.
   Assumes SYSREF is a registered signal of the core clock domain. */
`timescale 1ns/100ps
// Stands for a CML-driven output, one of the two styles, with LVPECL, that carry counted bursts.
module srpsc_sysref_receiver (
    input wire clock_i,
    input wire sysref_i,
    input wire clear_i,
    output reg [7:0] pulses_o,
    output reg [7:0] high_o
);
    reg last;
    reg [7:0] run;
    always @(posedge clock_i) begin
        last <= sysref_i;
        run <= sysref_i ? run + 8'h01 : 8'h00;
        pulses_o <= clear_i ? 8'h00 : pulses_o + {7'h00, sysref_i && !last};
        if (!sysref_i && last) begin
            high_o <= run;
        end
    end
endmodule // srpsc_sysref_receiver

// file: srpsc_tb.sv
/* Self-checking bench of the SYSREF pulse and sync control block.
   Assumes the checker and the receiver model are compiled first. */
`timescale 1ns/100ps
module tb;
    reg clock_i = 1'b0, rst_n_i = 1'b0, reg_write_i = 1'b0, serial_request_i = 1'b0, clear = 1'b1;
    reg general_input_pin_i = 1'b0, sync_pin_i = 1'b0, reference_input_zero_i = 1'b0;
    reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    reg [3:0] input_pin_function_select_i = 4'h0;
    reg [5:0] general_output_function_i = 6'h00;
    wire [7:0] reg_rdata_o, pulses, high;
    wire general_output_pin_o, sysref_o, reseed_pll2_o, reseed_direct_o, request_status_o;
    integer errors = 0, checks = 0, cyc = 0, n_p2 = 0, n_dir = 0, i, b;
    localparam [39:0] EXP = 40'h00_07_ff_0f_00;
    srpsc_control DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_write_i(reg_write_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .serial_request_i(serial_request_i),
        .general_input_pin_i(general_input_pin_i), .input_pin_function_select_i(input_pin_function_select_i),
        .sync_pin_i(sync_pin_i), .reference_input_zero_i(reference_input_zero_i),
        .general_output_function_i(general_output_function_i), .general_output_pin_o(general_output_pin_o),
        .sysref_o(sysref_o), .reseed_pll2_o(reseed_pll2_o), .reseed_direct_o(reseed_direct_o),
        .request_status_o(request_status_o));
    srpsc_sysref_receiver far_end (.clock_i(clock_i), .sysref_i(sysref_o), .clear_i(clear),
        .pulses_o(pulses), .high_o(high));
    initial forever #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (reseed_pll2_o === 1'b1) n_p2 <= n_p2 + 1;
        if (reseed_direct_o === 1'b1) n_dir <= n_dir + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            $display("mismatch %0t run too long", $time);
            stop_test;
        end
    end
    task tick(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Every write leaves an idle cycle so the strobe is never raised in the step that lowers it.
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_write_i <= 1'b1;
            tick(1);
            reg_write_i <= 1'b0;
            tick(1);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            reg_addr_i <= a;
            tick(2);
            chk(reg_rdata_o, e);
        end
    endtask
    task t_sync;
        begin
            b = n_dir;
            wr(8'h5b, 8'h04);
            sync_pin_i <= 1'b1;
            tick(10);
            chk(8'(n_dir - b), 8'h00);
            reference_input_zero_i <= 1'b1;
            tick(6);
            chk(8'(n_dir - b), 8'h01);
            sync_pin_i <= 1'b0;
            reference_input_zero_i <= 1'b0;
            wr(8'h5b, 8'h02);
            sync_pin_i <= 1'b1;
            tick(6);
            chk(8'(n_p2), 8'h01);
            sync_pin_i <= 1'b0;
            wr(8'h5b, 8'h01);
            tick(6);
            chk(8'(n_dir - b), 8'h02);
            sync_pin_i <= 1'b1;
            wr(8'h5b, 8'h00);
            tick(6);
            chk(8'(n_dir - b), 8'h03);
            sync_pin_i <= 1'b0;
        end
    endtask
    task t_regs;
        for (i = 0; i < 5; i = i + 1) begin
            wr(8'h5a + i[7:0], (i == 0) ? 8'hf8 : 8'hff);
            rd(8'h5a + i[7:0], EXP[39 - 8 * i -: 8]);
        end
    endtask
    task t_burst;
        begin
            wr(8'h5b, 8'h00);
            wr(8'h5c, 8'h19);
            wr(8'h5d, 8'h00);
            rd(8'h10, 8'h00);
            for (i = 1; i < 7; i = i + 1) begin
                wr(8'h5a, i[7:0]);
                clear <= 1'b0;
                serial_request_i <= 1'b1;
                tick(900);
                chk(pulses, (i < 5) ? 8'h01 << (i - 1) : 8'h10);
                serial_request_i <= 1'b0;
                tick(4);
                chk({7'h00, sysref_o}, 8'h00);
                clear <= 1'b1;
            end
        end
    endtask
    task t_level;
        begin
            wr(8'h5a, 8'h00);
            input_pin_function_select_i <= 4'h8;
            general_output_function_i <= 6'h3e;
            clear <= 1'b0;
            general_input_pin_i <= 1'b1;
            tick(200);
            chk(pulses, 8'h04);
            chk({7'h00, general_output_pin_o}, 8'h01);
            general_input_pin_i <= 1'b0;
            tick(60);
            b = pulses;
            tick(100);
            chk(pulses, b[7:0]);
            input_pin_function_select_i <= 4'h7;
            general_input_pin_i <= 1'b1;
            tick(4);
            chk({7'h00, request_status_o}, 8'h00);
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d checks %0d", errors, checks);
            if (errors == 0 && checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        tick(5);
        rst_n_i <= 1'b1;
        tick(1);
        t_sync;
        t_regs;
        t_burst;
        t_level;
        clear <= 1'b1;
        wr(8'h5a, 8'h07);
        clear <= 1'b0;
        tick(200);
        chk(high, 8'h19);
        chk(pulses, 8'h04);
        stop_test;
    end
endmodule // tb
